//--- pid_regs.svh
`ifndef PID_REGS_SVH
`define PID_REGS_SVH

// opcode bytes
`define PID_OP_ADJUST_REQUESTED_PRIVILEGE_BYTE   8'h63
`define PID_OP_ESCAPE      8'h0F
`define PID_OP2_GRP0       8'h00
`define PID_OP2_GRP1       8'h01
`define PID_OP2_LAR        8'h02
`define PID_OP2_LSL        8'h03

// reg sub-field codes
`define PID_SUB_000        3'h0
`define PID_SUB_001        3'h1
`define PID_SUB_010        3'h2
`define PID_SUB_011        3'h3
`define PID_SUB_110        3'h6

// address-mode byte fields
`define PID_MOD_HI         7
`define PID_MOD_LO         6
`define PID_REG_HI         5
`define PID_REG_LO         3
`define PID_MOD_REGISTER   2'h3

// exception vectors
`define PID_EXC_INVALID_OP 5'h06
`define PID_EXC_GEN_PROT   5'h0D
`define PID_EXC_NONE       5'h00

// cycle counts, register/memory
`define PID_CYC_ADJUST_REQUESTED_PRIVILEGE_R     5'h14
`define PID_CYC_ADJUST_REQUESTED_PRIVILEGE_M     5'h15
`define PID_CYC_LAR_R      5'h0F
`define PID_CYC_LAR_M      5'h10
`define PID_CYC_LDT_TBL    5'h0B
`define PID_CYC_LOAD_LOCAL_TABLE_REG_R     5'h14
`define PID_CYC_LOAD_LOCAL_TABLE_REG_M     5'h18
`define PID_CYC_LOAD_MACHINE_STATUS_WORD_R     5'h0B
`define PID_CYC_LOAD_MACHINE_STATUS_WORD_M     5'h0E
`define PID_CYC_LSLB_R     5'h15
`define PID_CYC_LSLB_M     5'h16
`define PID_CYC_LSLP_R     5'h19
`define PID_CYC_LSLP_M     5'h1A
`define PID_CYC_LTR_R      5'h17
`define PID_CYC_LTR_M      5'h1B
`define PID_CYC_STBL       5'h09
`define PID_CYC_STORE_LOCAL_TABLE_REG       5'h02
`define PID_CYC_ZERO       5'h00
`define PID_CYC_ONE        5'h01

`define PID_CPL_KERNEL     2'h0

`endif

//--- pid_pkg.sv
package pid_pkg;

    typedef enum logic [3:0] {
        PID_OP_NONE      = 4'h0,
        PID_OP_ADJ_RPL   = 4'h1,
        PID_OP_LD_AR     = 4'h2,
        PID_OP_LD_GDT    = 4'h3,
        PID_OP_LD_IDT    = 4'h4,
        PID_OP_LD_LDT    = 4'h5,
        PID_OP_LD_MSW    = 4'h6,
        PID_OP_LD_LIMIT  = 4'h7,
        PID_OP_LD_TR     = 4'h8,
        PID_OP_ST_GDT    = 4'h9,
        PID_OP_ST_IDT    = 4'hA,
        PID_OP_ST_LDT    = 4'hB
    } pid_op_t;

    typedef enum logic [1:0] {
        PID_ST_OPC  = 2'b00,
        PID_ST_OP2  = 2'b01,
        PID_ST_MODRM = 2'b10,
        PID_ST_EXEC = 2'b11
    } pid_state_t;

    // one decoded instruction, handed to the cycle timer
    typedef struct packed {
        pid_op_t    op;
        logic       mem_src;
        logic       page_gran;
        logic       prot_only;
        logic       priv_load;
        logic       tbl_lock;
        logic       sel_check;
        logic [4:0] cycles;
    } pid_decode_t;

    // outcome reported when an instruction retires or faults
    typedef struct packed {
        pid_op_t    op;
        logic       fault;
        logic [4:0] vector;
        logic       zf_clear;
    } pid_result_t;

endpackage : pid_pkg

//--- pid_cost.sv
`timescale 1ns/1ps
`include "pid_regs.svh"

module pid_cost
    import pid_pkg::*;
(
    input  wire logic [7:0] op2_byte,
    input  wire logic       escaped,
    input  wire logic [7:0] modrm_byte,
    input  wire logic       page_gran,
    output pid_decode_t     dec
);

    logic [2:0] sub;
    logic       mem;

    function automatic logic [4:0] pick(input logic m,
                                        input logic [4:0] r,
                                        input logic [4:0] mm);
        pick = m ? mm : r;
    endfunction : pick

    assign sub = modrm_byte[`PID_REG_HI:`PID_REG_LO];
    assign mem = modrm_byte[`PID_MOD_HI:`PID_MOD_LO] != `PID_MOD_REGISTER;

    always_comb
    begin
        dec           = '0;
        dec.op        = PID_OP_NONE;
        dec.mem_src   = mem;
        dec.page_gran = page_gran;
        if (!escaped)
        begin
            dec.op        = PID_OP_ADJ_RPL;
            dec.prot_only = 1'b1;
            dec.cycles    = pick(mem, `PID_CYC_ADJUST_REQUESTED_PRIVILEGE_R, `PID_CYC_ADJUST_REQUESTED_PRIVILEGE_M);
        end
        else if (op2_byte == `PID_OP2_LAR)
        begin
            dec.op        = PID_OP_LD_AR;
            dec.prot_only = 1'b1;
            dec.tbl_lock  = 1'b1;
            dec.sel_check = 1'b1;
            dec.cycles    = pick(mem, `PID_CYC_LAR_R, `PID_CYC_LAR_M);
        end
        else if (op2_byte == `PID_OP2_LSL)
        begin
            dec.op        = PID_OP_LD_LIMIT;
            dec.prot_only = 1'b1;
            dec.tbl_lock  = 1'b1;
            dec.sel_check = 1'b1;
            if (page_gran)
                dec.cycles = pick(mem, `PID_CYC_LSLP_R, `PID_CYC_LSLP_M);
            else
                dec.cycles = pick(mem, `PID_CYC_LSLB_R, `PID_CYC_LSLB_M);
        end
        else if (op2_byte == `PID_OP2_GRP1)
        begin
            case (sub)
                `PID_SUB_000:
                begin
                    dec.op     = PID_OP_ST_GDT;
                    dec.cycles = `PID_CYC_STBL;
                end
                `PID_SUB_001:
                begin
                    dec.op     = PID_OP_ST_IDT;
                    dec.cycles = `PID_CYC_STBL;
                end
                `PID_SUB_010:
                begin
                    dec.op        = PID_OP_LD_GDT;
                    dec.priv_load = 1'b1;
                    dec.cycles    = `PID_CYC_LDT_TBL;
                end
                `PID_SUB_011:
                begin
                    dec.op        = PID_OP_LD_IDT;
                    dec.priv_load = 1'b1;
                    dec.cycles    = `PID_CYC_LDT_TBL;
                end
                `PID_SUB_110:
                begin
                    dec.op     = PID_OP_LD_MSW;
                    dec.cycles = pick(mem, `PID_CYC_LOAD_MACHINE_STATUS_WORD_R, `PID_CYC_LOAD_MACHINE_STATUS_WORD_M);
                end
                default:
                    dec.op = PID_OP_NONE;
            endcase
        end
        else if (op2_byte == `PID_OP2_GRP0)
        begin
            dec.prot_only = 1'b1;
            case (sub)
                `PID_SUB_000:
                begin
                    dec.op     = PID_OP_ST_LDT;
                    dec.cycles = `PID_CYC_STORE_LOCAL_TABLE_REG;
                end
                `PID_SUB_010:
                begin
                    dec.op        = PID_OP_LD_LDT;
                    dec.priv_load = 1'b1;
                    dec.tbl_lock  = 1'b1;
                    dec.cycles    = pick(mem, `PID_CYC_LOAD_LOCAL_TABLE_REG_R, `PID_CYC_LOAD_LOCAL_TABLE_REG_M);
                end
                `PID_SUB_011:
                begin
                    dec.op        = PID_OP_LD_TR;
                    dec.priv_load = 1'b1;
                    dec.tbl_lock  = 1'b1;
                    dec.cycles    = pick(mem, `PID_CYC_LTR_R, `PID_CYC_LTR_M);
                end
                default:
                    dec.prot_only = 1'b0;
            endcase
        end
    end

endmodule : pid_cost

//--- pid_timer.sv
`timescale 1ns/1ps
`include "pid_regs.svh"

module pid_timer
    import pid_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       load,
    input  wire logic [4:0] cycles,
    output logic            busy,
    output logic            last
);

    logic [4:0] count_reg;
    logic [4:0] count_next;

    always_comb
    begin
        count_next = count_reg;
        if (load)
            count_next = cycles;
        else if (count_reg != `PID_CYC_ZERO)
            count_next = count_reg - `PID_CYC_ONE;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            count_reg <= `PID_CYC_ZERO;
        else
            count_reg <= count_next;
    end

    assign busy = count_reg != `PID_CYC_ZERO;
    assign last = count_reg == `PID_CYC_ONE;

endmodule : pid_timer

//--- pid_decoder.sv
`timescale 1ns/1ps
`include "pid_regs.svh"

module pid_decoder
    import pid_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  fetch_byte,
    input  wire logic        fetch_valid,
    output logic             fetch_ready,
    input  wire logic        prot_mode,
    input  wire logic [1:0]  current_privilege_level,
    input  wire logic        page_gran,
    input  wire logic        sel_fail,
    output logic             bus_lock,
    output logic             busy,
    output logic             done,
    output pid_result_t      result
);

    ////////////////////////////////////////////////////////////////////////
    pid_state_t  state_reg;
    pid_state_t  state_next;
    logic        esc_reg;
    logic        esc_next;
    logic [7:0]  op2_reg;
    logic [7:0]  op2_next;
    pid_decode_t cur_reg;
    pid_decode_t cur_next;
    pid_result_t result_reg;
    pid_result_t result_next;
    logic        done_reg;
    logic        done_next;
    logic        zf_reg;
    logic        zf_next;
    logic        take;
    logic        timer_load;
    logic        timer_busy;
    logic        timer_last;
    logic        fault;
    logic [4:0]  vector;
    pid_decode_t dec;

    ////////////////////////////////////////////////////////////////////////
    pid_cost u_cost (
        .op2_byte   (op2_reg),
        .escaped    (esc_reg),
        .modrm_byte (fetch_byte),
        .page_gran  (page_gran),
        .dec        (dec)
    );

    pid_timer u_timer (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .load    (timer_load),
        .cycles  (dec.cycles),
        .busy    (timer_busy),
        .last    (timer_last)
    );

    ////////////////////////////////////////////////////////////////////////
    // bytes are only accepted while no instruction is executing
    assign fetch_ready = state_reg != PID_ST_EXEC;
    assign take        = fetch_valid && fetch_ready;

    always_comb
    begin
        fault  = 1'b0;
        vector = `PID_EXC_NONE;
        if (dec.prot_only && !prot_mode)
        begin
            fault  = 1'b1;
            vector = `PID_EXC_INVALID_OP;
        end
        else if (dec.priv_load
                 && current_privilege_level != `PID_CPL_KERNEL)
        begin
            fault  = 1'b1;
            vector = `PID_EXC_GEN_PROT;
        end
    end

    assign timer_load = state_reg == PID_ST_MODRM && take
                        && dec.op != PID_OP_NONE && !fault;

    always_comb
    begin
        state_next  = state_reg;
        esc_next    = esc_reg;
        op2_next    = op2_reg;
        cur_next    = cur_reg;
        result_next = result_reg;
        done_next   = 1'b0;
        zf_next     = zf_reg;
        case (state_reg)
            PID_ST_OPC:
            begin
                if (take)
                begin
                    if (fetch_byte == `PID_OP_ESCAPE)
                    begin
                        esc_next   = 1'b1;
                        state_next = PID_ST_OP2;
                    end
                    else if (fetch_byte == `PID_OP_ADJUST_REQUESTED_PRIVILEGE_BYTE)
                    begin
                        esc_next   = 1'b0;
                        state_next = PID_ST_MODRM;
                    end
                end
            end
            PID_ST_OP2:
            begin
                if (take)
                begin
                    op2_next = fetch_byte;
                    if (fetch_byte == `PID_OP2_GRP0
                        || fetch_byte == `PID_OP2_GRP1
                        || fetch_byte == `PID_OP2_LAR
                        || fetch_byte == `PID_OP2_LSL)
                        state_next = PID_ST_MODRM;
                    else
                        state_next = PID_ST_OPC;
                end
            end
            PID_ST_MODRM:
            begin
                if (take)
                begin
                    cur_next   = dec;
                    zf_next    = 1'b0;
                    state_next = PID_ST_OPC;
                    if (dec.op != PID_OP_NONE && fault)
                    begin
                        result_next.op       = dec.op;
                        result_next.fault    = 1'b1;
                        result_next.vector   = vector;
                        result_next.zf_clear = 1'b0;
                        done_next            = 1'b1;
                    end
                    else if (dec.op != PID_OP_NONE)
                        state_next = PID_ST_EXEC;
                end
            end
            PID_ST_EXEC:
            begin
                if (cur_reg.sel_check && sel_fail)
                    zf_next = 1'b1;
                if (timer_last)
                begin
                    result_next.op       = cur_reg.op;
                    result_next.fault    = 1'b0;
                    result_next.vector   = `PID_EXC_NONE;
                    result_next.zf_clear = zf_next;
                    done_next            = 1'b1;
                    state_next           = PID_ST_OPC;
                end
            end
            default:
                state_next = PID_ST_OPC;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            state_reg  <= PID_ST_OPC;
            esc_reg    <= 1'b0;
            op2_reg    <= 8'h00;
            cur_reg    <= '0;
            result_reg <= '0;
            done_reg   <= 1'b0;
            zf_reg     <= 1'b0;
        end
        else
        begin
            state_reg  <= state_next;
            esc_reg    <= esc_next;
            op2_reg    <= op2_next;
            cur_reg    <= cur_next;
            result_reg <= result_next;
            done_reg   <= done_next;
            zf_reg     <= zf_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // lock during table accesses
    assign bus_lock = state_reg == PID_ST_EXEC && cur_reg.tbl_lock;
    assign busy     = timer_busy;
    assign done     = done_reg;
    assign result   = result_reg;

    ////////////////////////////////////////////////////////////////////////
    sequence lds_fetch_s;
        state_reg == PID_ST_MODRM && take && dec.op == PID_OP_LD_LDT
        && !fault && dec.mem_src;
    endsequence

    sequence store_local_table_reg_fetch_s;
        state_reg == PID_ST_MODRM && take && dec.op == PID_OP_ST_LDT
        && !fault;
    endsequence

    cost_adjust_requested_privilege_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (timer_load && dec.op == PID_OP_ADJ_RPL)
        |-> dec.cycles == (dec.mem_src ? 5'h15 : 5'h14))
        else $error("adjust privilege cost wrong");

    cost_lar_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (timer_load && dec.op == PID_OP_LD_AR)
        |-> dec.cycles == (dec.mem_src ? 5'h10 : 5'h0F))
        else $error("access rights cost wrong");

    cost_gdt_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (timer_load && dec.op == PID_OP_LD_GDT) |-> dec.cycles == 5'h0B)
        else $error("global table load cost wrong");

    cost_idt_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (timer_load && dec.op == PID_OP_LD_IDT) |-> dec.cycles == 5'h0B)
        else $error("interrupt table load cost wrong");

    ldt_done_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        lds_fetch_s |=> (!done)[*8] ##17 done)
        else $error("local table load memory timing wrong");

    cost_msw_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (timer_load && dec.op == PID_OP_LD_MSW)
        |-> dec.cycles == (dec.mem_src ? 5'h0E : 5'h0B))
        else $error("status word cost wrong");

    cost_lsl_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (timer_load && dec.op == PID_OP_LD_LIMIT && dec.page_gran)
        |-> dec.cycles == (dec.mem_src ? 5'h1A : 5'h19))
        else $error("page limit cost wrong");

    cost_ltr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (timer_load && dec.op == PID_OP_LD_TR)
        |-> dec.cycles == (dec.mem_src ? 5'h1B : 5'h17))
        else $error("task register cost wrong");

    store_local_table_reg_done_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        store_local_table_reg_fetch_s |=> !done ##2 done)
        else $error("local table store timing wrong");

    real_invalid_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_reg == PID_ST_MODRM && take && dec.prot_only && !prot_mode)
        |=> done && result.fault && result.vector == 5'h06)
        else $error("real mode did not raise invalid opcode");

    priv_fault_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_reg == PID_ST_MODRM && take && dec.priv_load && prot_mode
         && current_privilege_level != 2'h0)
        |=> done && result.vector == 5'h0D)
        else $error("privilege fault missing");

    lock_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (timer_load && dec.tbl_lock) |=> bus_lock throughout timer_busy[*1])
        else $error("bus lock not asserted");

endmodule : pid_decoder

//--- pid_fetch_model.sv
`timescale 1ns/1ps

// prefetch queue stand-in: each byte is held until the decoder takes it
module pid_fetch_model
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       fetch_ready,
    input  wire logic [1:0] gap,
    output logic [7:0]      fetch_byte,
    output logic            fetch_valid,
    output logic            last_taken
);

    logic [7:0] q [$];
    int         idle;

    task automatic push(input logic [7:0] b);
        q.push_back(b);
    endtask : push

    initial
    begin
        fetch_byte = 8'hA5;
        fetch_valid = 1'b0;
        last_taken = 1'b0;
        idle = 0;
    end

    ////////////////////////////////////////////////////////////////////////
    // idle byte toggles so a stale value never passes for a fresh one
    always @(posedge sys_clk)
    begin
        logic taken;
        taken = rst_n && fetch_valid && fetch_ready;
        last_taken <= taken && (q.size() == 1);
        if (taken)
        begin
            void'(q.pop_front());
            idle = gap;
        end
        else if (idle != 0)
            idle = idle - 1;
        if (rst_n && q.size() != 0 && idle == 0)
        begin
            fetch_valid <= 1'b1;
            fetch_byte <= q[0];
        end
        else
        begin
            fetch_valid <= 1'b0;
            fetch_byte <= ~fetch_byte;
        end
    end

endmodule : pid_fetch_model

//--- pid_decoder_tb.sv
`timescale 1ns/1ps

module pid_decoder_tb;

    logic                 sys_clk;
    logic                 rst_n;
    logic [7:0]           fetch_byte;
    logic                 fetch_valid;
    logic                 fetch_ready;
    logic                 prot_mode;
    logic [1:0]           current_privilege_level;
    logic                 page_gran;
    logic                 sel_fail;
    logic                 bus_lock;
    logic                 busy;
    logic                 done;
    pid_pkg::pid_result_t result;
    logic [1:0]           gap;
    logic                 last_taken;
    int                   miscompares;
    int                   checks_done;
    int                   cycle_cnt;

    always #50 sys_clk = ~sys_clk;

    pid_decoder i_pid_decoder (
        .sys_clk(sys_clk), .rst_n(rst_n), .fetch_byte(fetch_byte),
        .fetch_valid(fetch_valid), .fetch_ready(fetch_ready),
        .prot_mode(prot_mode),
        .current_privilege_level(current_privilege_level),
        .page_gran(page_gran), .sel_fail(sel_fail), .bus_lock(bus_lock),
        .busy(busy), .done(done), .result(result));

    pid_fetch_model i_pid_fetch_model (
        .sys_clk(sys_clk), .rst_n(rst_n), .fetch_ready(fetch_ready),
        .gap(gap), .fetch_byte(fetch_byte), .fetch_valid(fetch_valid),
        .last_taken(last_taken));

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    // cut a hang short; whole run needs well under 3000 cycles
    always @(posedge sys_clk)
    begin
        cycle_cnt++;
        if (cycle_cnt == 6000)
        begin
            miscompares++;
            conclude();
        end
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic mode(input logic p, input logic [1:0] c,
                        input logic pg, input logic sf);
        prot_mode = p;
        current_privilege_level = c;
        page_gran = pg;
        sel_fail = sf;
    endtask : mode

    // latency counted from the edge that took the mode byte
    task automatic issue(input logic [7:0] b0, input logic [7:0] b1,
                         input logic [7:0] b2, input logic [3:0] op,
                         input logic [4:0] cyc, input logic [4:0] vec,
                         input logic lock, input logic zf);
        int k;
        int want;
        i_pid_fetch_model.push(b0);
        i_pid_fetch_model.push(b1);
        if (b0 != 8'h63)
            i_pid_fetch_model.push(b2);
        k = 0;
        while (last_taken !== 1'b1 && k < 200)
        begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        k = 0;
        while (done !== 1'b1 && k < 64)
        begin
            @(posedge sys_clk);
            #1;
            k++;
            if (k == 1 && vec == 5'h00)
            begin
                check("busy", busy, 1'b1);
                check("bus_lock", bus_lock, lock);
                check("fetch_ready", fetch_ready, 1'b0);
            end
        end
        // done follows the load edge by the cost; a fault retires at once
        want = (vec == 5'h00) ? cyc : 0;
        check("latency", k, want);
        check("vector", result.vector, vec);
        check("fault", result.fault, vec != 5'h00);
        check("zf_clear", result.zf_clear, zf);
        if (vec == 5'h00)
            check("op", result.op, op);
        @(posedge sys_clk);
        #1;
        check("done_width", done, 1'b0);
    endtask : issue

    ////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        check("done", done, 1'b0);
        check("busy", busy, 1'b0);
        check("bus_lock", bus_lock, 1'b0);
        check("fetch_ready", fetch_ready, 1'b1);
        check("result", result, 11'h000);
    endtask : test_reset

    task automatic test_adjust();
        mode(1'b1, 2'h3, 1'b0, 1'b0);
        gap = 2'h1;
        issue(8'h63, 8'hC0, 8'h00, 4'h1, 5'h14, 5'h00, 1'b0, 1'b0);
        gap = 2'h0;
        issue(8'h63, 8'h00, 8'h00, 4'h1, 5'h15, 5'h00, 1'b0, 1'b0);
    endtask : test_adjust

    // global and interrupt table loads and stores also run in real mode
    task automatic test_group1();
        mode(1'b0, 2'h0, 1'b0, 1'b0);
        issue(8'h0F, 8'h01, 8'h10, 4'h3, 5'h0B, 5'h00, 1'b0, 1'b0);
        issue(8'h0F, 8'h01, 8'hD8, 4'h4, 5'h0B, 5'h00, 1'b0, 1'b0);
        issue(8'h0F, 8'h01, 8'hF0, 4'h6, 5'h0B, 5'h00, 1'b0, 1'b0);
        issue(8'h0F, 8'h01, 8'h30, 4'h6, 5'h0E, 5'h00, 1'b0, 1'b0);
        issue(8'h0F, 8'h01, 8'h00, 4'h9, 5'h09, 5'h00, 1'b0, 1'b0);
        issue(8'h0F, 8'h01, 8'hC8, 4'hA, 5'h09, 5'h00, 1'b0, 1'b0);
        mode(1'b1, 2'h0, 1'b0, 1'b0);
        issue(8'h0F, 8'h01, 8'hD0, 4'h3, 5'h0B, 5'h00, 1'b0, 1'b0);
    endtask : test_group1

    task automatic test_group0();
        mode(1'b1, 2'h0, 1'b0, 1'b0);
        issue(8'h0F, 8'h00, 8'hD0, 4'h5, 5'h14, 5'h00, 1'b1, 1'b0);
        issue(8'h0F, 8'h00, 8'h10, 4'h5, 5'h18, 5'h00, 1'b1, 1'b0);
        issue(8'h0F, 8'h00, 8'hD8, 4'h8, 5'h17, 5'h00, 1'b1, 1'b0);
        issue(8'h0F, 8'h00, 8'h18, 4'h8, 5'h1B, 5'h00, 1'b1, 1'b0);
        issue(8'h0F, 8'h00, 8'hC0, 4'hB, 5'h02, 5'h00, 1'b0, 1'b0);
        issue(8'h0F, 8'h00, 8'h00, 4'hB, 5'h02, 5'h00, 1'b0, 1'b0);
    endtask : test_group0

    // rights and limit loads are not privileged, so run them at level 3
    task automatic test_rights_limit();
        mode(1'b1, 2'h3, 1'b0, 1'b0);
        issue(8'h0F, 8'h02, 8'hC0, 4'h2, 5'h0F, 5'h00, 1'b1, 1'b0);
        issue(8'h0F, 8'h02, 8'h00, 4'h2, 5'h10, 5'h00, 1'b1, 1'b0);
        issue(8'h0F, 8'h03, 8'hC0, 4'h7, 5'h15, 5'h00, 1'b1, 1'b0);
        issue(8'h0F, 8'h03, 8'h00, 4'h7, 5'h16, 5'h00, 1'b1, 1'b0);
        mode(1'b1, 2'h3, 1'b1, 1'b1);
        issue(8'h0F, 8'h03, 8'hC0, 4'h7, 5'h19, 5'h00, 1'b1, 1'b1);
        issue(8'h0F, 8'h03, 8'h00, 4'h7, 5'h1A, 5'h00, 1'b1, 1'b1);
        issue(8'h0F, 8'h02, 8'h00, 4'h2, 5'h10, 5'h00, 1'b1, 1'b1);
    endtask : test_rights_limit

    task automatic test_faults();
        mode(1'b0, 2'h0, 1'b0, 1'b0);
        issue(8'h0F, 8'h00, 8'hD0, 4'h0, 5'h00, 5'h06, 1'b0, 1'b0);
        issue(8'h0F, 8'h03, 8'hC0, 4'h0, 5'h00, 5'h06, 1'b0, 1'b0);
        issue(8'h0F, 8'h00, 8'h18, 4'h0, 5'h00, 5'h06, 1'b0, 1'b0);
        issue(8'h0F, 8'h00, 8'hC0, 4'h0, 5'h00, 5'h06, 1'b0, 1'b0);
        mode(1'b0, 2'h3, 1'b0, 1'b0);
        issue(8'h0F, 8'h00, 8'h10, 4'h0, 5'h00, 5'h06, 1'b0, 1'b0);
        mode(1'b1, 2'h1, 1'b0, 1'b0);
        issue(8'h0F, 8'h01, 8'h10, 4'h0, 5'h00, 5'h0D, 1'b0, 1'b0);
        issue(8'h0F, 8'h01, 8'hD8, 4'h0, 5'h00, 5'h0D, 1'b0, 1'b0);
        mode(1'b1, 2'h3, 1'b0, 1'b0);
        issue(8'h0F, 8'h00, 8'h10, 4'h0, 5'h00, 5'h0D, 1'b0, 1'b0);
        issue(8'h0F, 8'h00, 8'hD8, 4'h0, 5'h00, 5'h0D, 1'b0, 1'b0);
    endtask : test_faults

    // unknown opcodes, second bytes and sub-fields drop; slow queue
    task automatic test_dropped();
        gap = 2'h2;
        mode(1'b1, 2'h0, 1'b0, 1'b0);
        i_pid_fetch_model.push(8'h90);
        i_pid_fetch_model.push(8'h0F);
        i_pid_fetch_model.push(8'h20);
        i_pid_fetch_model.push(8'h0F);
        i_pid_fetch_model.push(8'h01);
        i_pid_fetch_model.push(8'hE0);
        issue(8'h0F, 8'h01, 8'h08, 4'hA, 5'h09, 5'h00, 1'b0, 1'b0);
        gap = 2'h0;
    endtask : test_dropped

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        gap = 2'h0;
        miscompares = 0;
        checks_done = 0;
        cycle_cnt = 0;
        mode(1'b0, 2'h0, 1'b0, 1'b0);
        repeat (12) @(posedge sys_clk);
        #1;
        test_reset();
        rst_n = 1'b1;
        test_adjust();
        test_group1();
        test_group0();
        test_rights_limit();
        test_faults();
        test_dropped();
        conclude();
    end

endmodule : pid_decoder_tb
